//--- design/mode_select_memory_map_bus.sv
// Behaviour
// - mode chosen from mode pins at reset
// - single-chip reaches on-chip memory only
// - single-chip ports and handshakes are gpio
// - single-chip rom enabled from reset
// - expanded mode reaches whole 64k space
// - low address then data share pins
// - strobe high passes, falling edge holds
// - strobe, direction, address on every internal and external cycle
// - direction stays low across back-to-back writes
// - test mode is privileged expanded mode
// - bootstrap enables boot rom, runs it
// - bootstrap vectors come from boot rom
// - boot program loads ram, jumps zero
// - bootstrap interrupt vectors point into ram
// - on-chip addresses same both normal modes
// - option bits remove eeprom, and rom outside single-chip
// - ram at zero, movable 4k boundary
// - register block at 1000, movable
// - register block wins, low ram hidden
`timescale 1ns/1ps
`include "mode_map_consts.svh"
module mode_select_memory_map_bus
    import mode_map_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    // mode pins
    input wire logic mode_select_high_input_i,
    input wire logic mode_select_low_input_i,
    // core request
    input wire logic cpu_req_i,
    input wire logic cpu_we_i,
    input wire logic [15:0] cpu_addr_i,
    input wire logic [7:0] cpu_wdata_i,
    output logic cpu_ready_o,
    output logic cpu_ack_o,
    output logic [7:0] cpu_rdata_o,
    // map register and option bits
    input wire logic map_wr_i,
    input wire logic [3:0] map_ram_page_i,
    input wire logic [3:0] map_reg_page_i,
    input wire logic rom_disable_i,
    input wire logic eeprom_disable_i,
    // on-chip memories
    output region_type mem_region_o,
    output logic [15:0] mem_addr_o,
    output logic mem_stb_o,
    output logic mem_we_o,
    output logic [7:0] mem_wdata_o,
    input wire logic [7:0] mem_rdata_i,
    // general-purpose side
    input wire logic [7:0] gpio_b_i,
    input wire logic [7:0] gpio_c_i,
    input wire logic gpio_c_oe_i,
    input wire logic gpio_hs_b_i,
    output logic [7:0] gpio_c_o,
    output logic gpio_hs_a_o,
    // pins
    output logic [7:0] port_b_o,
    input wire logic [7:0] port_c_i,
    output logic [7:0] port_c_o,
    output logic port_c_oe_o,
    input wire logic handshake_line_a_i,
    output logic handshake_line_a_o,
    output logic handshake_line_a_oe_o,
    output logic handshake_line_b_o,
    output logic handshake_line_b_oe_o,
    output logic e_clock_o,
    // status
    output mode_type mode_o,
    output logic mode_valid_o,
    output logic option_write_enable_o
);
    typedef struct packed {
        logic [2:0] phase;
        cycle_type cycle;
        logic we;
        logic [15:0] addr;
        logic [15:0] mapped;
        logic [7:0] wdata;
        region_type region;
        logic rw;
        logic ack;
        logic [7:0] rdata;
        logic [3:0] ram_page;
        logic [3:0] reg_page;
        logic [7:0] c1;
        logic [7:0] c2;
        logic [7:0] c3;
        logic [7:0] c_stable;
        logic a1;
        logic a2;
        logic a3;
        logic a_stable;
        logic [7:0] pb;
        logic [7:0] pc;
        logic pc_oe;
        logic hs_a;
        logic hs_a_oe;
        logic hs_b;
        logic hs_b_oe;
        logic e;
        logic mem_stb;
    } bus_state_type;

    bus_state_type q;
    bus_state_type next_q;
    logic take;
    logic bus_mode;

    map_carrier_if carrier();

    mode_latch u_mode_latch (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .mode_select_high_input_i(mode_select_high_input_i),
        .mode_select_low_input_i(mode_select_low_input_i),
        .bus(carrier.latch)
    );

    map_decoder u_map_decoder (
        .bus(carrier.decoder)
    );

    function automatic logic is_bus_mode(input mode_type m, input logic valid);
        // test mode runs the expanded bus
        return valid && (m == MODE_EXPANDED || m == MODE_TEST);
    endfunction

    assign carrier.addr = cpu_addr_i;
    assign carrier.ram_page = q.ram_page;
    assign carrier.reg_page = q.reg_page;
    assign carrier.rom_disable = rom_disable_i;
    assign carrier.eeprom_disable = eeprom_disable_i;

    // requests wait for the latched mode so no cycle runs on a guessed map
    assign cpu_ready_o = carrier.mode_valid && (q.phase == `PHASE_LAST);
    assign take = cpu_req_i && cpu_ready_o;
    assign bus_mode = is_bus_mode(carrier.mode, carrier.mode_valid);

    always_comb
    begin
        next_q = q;
        next_q.phase = q.phase + 3'h1;
        next_q.ack = 1'b0;

        // pin inputs pass three flops, accepted when the last two agree
        next_q.c1 = port_c_i;
        next_q.c2 = q.c1;
        next_q.c3 = q.c2;
        if (q.c2 == q.c3)
            next_q.c_stable = q.c3;
        next_q.a1 = handshake_line_a_i;
        next_q.a2 = q.a1;
        next_q.a3 = q.a2;
        if (q.a2 == q.a3)
            next_q.a_stable = q.a3;

        if (map_wr_i)
        begin
            next_q.ram_page = map_ram_page_i;
            next_q.reg_page = map_reg_page_i;
        end

        if (q.phase == `PHASE_LAST)
        begin
            case (q.cycle)
                CYCLE_INTERNAL:
                begin
                    next_q.ack = 1'b1;
                    if (q.region == REGION_NONE)
                        next_q.rdata = `OPEN_BUS_READ;
                    else
                        next_q.rdata = mem_rdata_i;
                end
                CYCLE_EXTERNAL:
                begin
                    next_q.ack = 1'b1;
                    // data taken from the clock-high half
                    // the agreed value of this edge, one flop sooner than c_stable
                    next_q.rdata = next_q.c_stable;
                end
                default:
                begin
                    next_q.ack = 1'b0;
                end
            endcase
            next_q.cycle = CYCLE_IDLE;
            next_q.rw = 1'b1;
            if (take)
            begin
                next_q.we = cpu_we_i;
                next_q.addr = cpu_addr_i;
                next_q.mapped = carrier.mapped_addr;
                next_q.wdata = cpu_wdata_i;
                next_q.region = carrier.region;
                next_q.rw = !cpu_we_i;
                if (carrier.region == REGION_EXTERNAL)
                    next_q.cycle = CYCLE_EXTERNAL;
                else
                    next_q.cycle = CYCLE_INTERNAL;
            end
        end

        // on-chip memories see one strobe, in the last phase
        next_q.mem_stb = (next_q.cycle == CYCLE_INTERNAL) && (next_q.region != REGION_NONE)
                         && (next_q.phase == `PHASE_LAST);

        // e clock runs freely, high in the second half
        next_q.e = (next_q.phase >= `E_HIGH_FIRST);

        if (bus_mode)
        begin
            next_q.pb = next_q.addr[`ADDR_HI];
            // low address first, data second half
            if (next_q.phase < `E_HIGH_FIRST)
            begin
                next_q.pc = next_q.addr[`ADDR_LO];
                next_q.pc_oe = (next_q.cycle != CYCLE_IDLE);
            end
            else
            begin
                next_q.pc = next_q.wdata;
                next_q.pc_oe = (next_q.cycle != CYCLE_IDLE) && next_q.we;
            end
            // internal cycles also drive the bus
            // strobe high early, falls to latch
            next_q.hs_a = (next_q.cycle != CYCLE_IDLE) && (next_q.phase <= `AS_LAST);
            next_q.hs_a_oe = 1'b1;
            // direction and e feed outside write enable
            next_q.hs_b = next_q.rw;
            next_q.hs_b_oe = 1'b1;
        end
        else
        begin
            // ports act as plain parallel i/o
            next_q.pb = gpio_b_i;
            next_q.pc = gpio_c_i;
            next_q.pc_oe = gpio_c_oe_i;
            next_q.hs_a = 1'b0;
            next_q.hs_a_oe = 1'b0;
            next_q.hs_b = gpio_hs_b_i;
            next_q.hs_b_oe = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            q <= '0;
            q.phase <= `PHASE_FIRST;
            q.cycle <= CYCLE_IDLE;
            q.region <= REGION_NONE;
            q.rw <= 1'b1;
            q.ram_page <= `RAM_RESET_PAGE;
            // registers start at their reset page
            q.reg_page <= `REG_RESET_PAGE;
            q.hs_b_oe <= 1'b1;
        end
        else
        begin
            q <= next_q;
        end
    end

    // core answer
    assign cpu_ack_o = q.ack;
    assign cpu_rdata_o = q.rdata;

    // on-chip memories
    assign mem_region_o = q.region;
    // boot program is fetched through this path
    assign mem_addr_o = q.mapped;
    assign mem_stb_o = q.mem_stb;
    assign mem_we_o = q.mem_stb && q.we;
    assign mem_wdata_o = q.wdata;

    // general-purpose inputs
    assign gpio_c_o = q.c_stable;
    assign gpio_hs_a_o = q.a_stable;

    // pins
    assign port_b_o = q.pb;
    assign port_c_o = q.pc;
    assign port_c_oe_o = q.pc_oe;
    assign handshake_line_a_o = q.hs_a;
    assign handshake_line_a_oe_o = q.hs_a_oe;
    assign handshake_line_b_o = q.hs_b;
    assign handshake_line_b_oe_o = q.hs_b_oe;
    assign e_clock_o = q.e;

    // status
    assign mode_o = carrier.mode;
    assign mode_valid_o = carrier.mode_valid;
    // option and calibration writes only in test mode
    assign option_write_enable_o = carrier.mode_valid && (carrier.mode == MODE_TEST);
endmodule

//--- design/mode_map_consts.svh
`ifndef MODE_MAP_CONSTS_SVH
`define MODE_MAP_CONSTS_SVH
`define PIN_CODE_BOOTSTRAP 2'h0
`define PIN_CODE_SINGLE_CHIP 2'h1
`define PIN_CODE_TEST 2'h2
`define PIN_CODE_EXPANDED 2'h3
`define SETTLE_LAST 2'h3
`define RAM_RESET_PAGE 4'h0
`define REG_RESET_PAGE 4'h1
`define REG_BLOCK_MASK 12'hfc0
`define RAM_MASK 12'he00
`define PAGE 15:12
`define OFFSET 11:0
`define ADDR_HI 15:8
`define ADDR_LO 7:0
`define ROM_BASE 16'hd000
`define EEPROM_BASE 16'hb600
`define EEPROM_LAST 16'hb7ff
`define BOOT_ROM_BASE 16'hbf00
`define BOOT_ROM_LAST 16'hbfff
`define VECTOR_BASE 16'hffc0
`define BOOT_VECTOR_BASE 16'hbfc0
`define VECTOR_MASK 16'h003f
`define PHASE_FIRST 3'h0
`define AS_LAST 3'h1
`define E_HIGH_FIRST 3'h4
`define PHASE_LAST 3'h7
`define OPEN_BUS_READ 8'hff
`endif

//--- design/mode_map_pkg.sv
package mode_map_pkg;
    typedef enum logic [1:0] {MODE_SINGLE_CHIP, MODE_EXPANDED, MODE_BOOTSTRAP, MODE_TEST} mode_type;
    typedef enum logic [2:0] {
        REGION_NONE, REGION_REGS, REGION_RAM, REGION_ROM,
        REGION_EEPROM, REGION_BOOT_ROM, REGION_EXTERNAL
    } region_type;
    typedef enum logic [1:0] {CYCLE_IDLE, CYCLE_INTERNAL, CYCLE_EXTERNAL} cycle_type;
    typedef struct packed {
        logic [1:0] s1;
        logic [1:0] s2;
        logic [1:0] s3;
        logic [1:0] settle;
        logic captured;
        mode_type mode;
    } latch_state_type;
endpackage

//--- design/map_carrier_if.sv
`timescale 1ns/1ps
interface map_carrier_if;
    import mode_map_pkg::*;
    mode_map_pkg::mode_type mode;
    logic mode_valid;
    logic [15:0] addr;
    logic [3:0] ram_page;
    logic [3:0] reg_page;
    logic rom_disable;
    logic eeprom_disable;
    mode_map_pkg::region_type region;
    logic [15:0] mapped_addr;
    modport latch (output mode, output mode_valid);
    modport decoder (
        input mode, input addr, input ram_page, input reg_page,
        input rom_disable, input eeprom_disable,
        output region, output mapped_addr
    );
    modport top (
        input mode, input mode_valid, input region, input mapped_addr,
        output addr, output ram_page, output reg_page,
        output rom_disable, output eeprom_disable
    );
endinterface

//--- design/mode_latch.sv
`timescale 1ns/1ps
`include "mode_map_consts.svh"
module mode_latch
    import mode_map_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic mode_select_high_input_i,
    input wire logic mode_select_low_input_i,
    map_carrier_if.latch bus
);
    latch_state_type q;
    latch_state_type next_q;

    always_comb
    begin
        next_q = q;
        next_q.s1 = {mode_select_high_input_i, mode_select_low_input_i};
        next_q.s2 = q.s1;
        next_q.s3 = q.s2;
        if (!q.captured)
        begin
            if (q.settle != `SETTLE_LAST)
                next_q.settle = q.settle + 2'h1;
            else if (q.s2 == q.s3)
            begin
                next_q.captured = 1'b1;
                case (q.s3)
                    `PIN_CODE_BOOTSTRAP: next_q.mode = MODE_BOOTSTRAP;
                    `PIN_CODE_TEST: next_q.mode = MODE_TEST;
                    `PIN_CODE_EXPANDED: next_q.mode = MODE_EXPANDED;
                    default: next_q.mode = MODE_SINGLE_CHIP;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            q <= '{s1: '0, s2: '0, s3: '0, settle: '0, captured: 1'b0, mode: MODE_SINGLE_CHIP};
        else
            q <= next_q;
    end

    assign bus.mode = q.mode;
    assign bus.mode_valid = q.captured;
endmodule

//--- design/map_decoder.sv
`timescale 1ns/1ps
`include "mode_map_consts.svh"
module map_decoder
    import mode_map_pkg::*;
(
    map_carrier_if.decoder bus
);
    function automatic logic on_page(input logic [15:0] a, input logic [3:0] page,
                                     input logic [11:0] mask);
        return (a[`PAGE] == page) && ((a[`OFFSET] & mask) == '0);
    endfunction

    logic boot;
    logic rom_on;

    always_comb
    begin
        boot = (bus.mode == MODE_BOOTSTRAP);
        rom_on = !bus.rom_disable || (bus.mode == MODE_SINGLE_CHIP);
        bus.mapped_addr = bus.addr;
        // boot rom vectors jump into ram
        if (boot && ((bus.addr & ~`VECTOR_MASK) == `VECTOR_BASE))
            bus.mapped_addr = `BOOT_VECTOR_BASE | (bus.addr & `VECTOR_MASK);
        if (on_page(bus.mapped_addr, bus.reg_page, `REG_BLOCK_MASK))
            bus.region = REGION_REGS;
        else if (on_page(bus.mapped_addr, bus.ram_page, `RAM_MASK))
            bus.region = REGION_RAM;
        else if (boot && bus.mapped_addr >= `BOOT_ROM_BASE && bus.mapped_addr <= `BOOT_ROM_LAST)
            bus.region = REGION_BOOT_ROM;
        else if (!bus.eeprom_disable && bus.mapped_addr >= `EEPROM_BASE
                 && bus.mapped_addr <= `EEPROM_LAST)
            bus.region = REGION_EEPROM;
        else if (rom_on && bus.mapped_addr >= `ROM_BASE)
            bus.region = REGION_ROM;
        else if (bus.mode == MODE_EXPANDED || bus.mode == MODE_TEST)
            bus.region = REGION_EXTERNAL;
        else
            bus.region = REGION_NONE;
    end
endmodule

//--- verification/mode_map_sva.sv
`timescale 1ns/1ps
module mode_map_sva
    import mode_map_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    // core side
    input wire logic cpu_req_i,
    input wire logic cpu_we_i,
    input wire logic [15:0] cpu_addr_i,
    input wire logic [7:0] cpu_wdata_i,
    input wire logic cpu_ready_o,
    input wire logic cpu_ack_o,
    // pins
    input wire logic [7:0] port_b_o,
    input wire logic [7:0] port_c_o,
    input wire logic port_c_oe_o,
    input wire logic handshake_line_a_o,
    input wire logic handshake_line_a_oe_o,
    input wire logic handshake_line_b_o,
    input wire logic e_clock_o,
    // memories and status
    input wire logic mem_stb_o,
    input wire region_type mem_region_o,
    input wire logic [15:0] mem_addr_o,
    input wire mode_type mode_o,
    input wire logic mode_valid_o
);
    logic bus;
    logic take;
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!reset_n_i);
    // test mode rides the same bus as expanded
    assign bus = mode_valid_o && (mode_o == MODE_EXPANDED || mode_o == MODE_TEST);
    assign take = cpu_req_i && cpu_ready_o;
    AST_ADDR_PHASE:
    assert property (bus && take |=> handshake_line_a_o && port_c_oe_o
        && port_b_o == $past(cpu_addr_i[15:8]) && port_c_o == $past(cpu_addr_i[7:0]))
        else $error("address phase wrong");
    AST_STROBE_WIDTH:
    assert property ($rose(handshake_line_a_o) |-> handshake_line_a_o [*2] ##1 !handshake_line_a_o)
        else $error("strobe width wrong");
    AST_ACK_TIME:
    assert property (take |-> ##9 cpu_ack_o)
        else $error("ack late or missing");
    AST_WRITE_DIR:
    assert property (bus && take && cpu_we_i |=> !handshake_line_b_o [*8])
        else $error("direction not low on write");
    AST_WRITE_DATA:
    assert property (bus && take && cpu_we_i |-> ##5 port_c_oe_o
        && port_c_o == $past(cpu_wdata_i, 5))
        else $error("write data phase wrong");
    AST_READ_RELEASE:
    assert property (bus && take && !cpu_we_i |=> handshake_line_b_o ##4 !port_c_oe_o [*3])
        else $error("read data phase not released");
    AST_E_PERIOD:
    assert property ($rose(e_clock_o) |-> e_clock_o [*4] ##1 !e_clock_o [*4] ##1 e_clock_o)
        else $error("bus phase clock shape wrong");
    AST_NO_BUS_SINGLE:
    assert property (mode_valid_o && (mode_o == MODE_SINGLE_CHIP || mode_o == MODE_BOOTSTRAP)
        |-> !handshake_line_a_oe_o && !handshake_line_a_o)
        else $error("strobe driven outside bus modes");
    AST_MODE_HELD:
    assert property ($past(mode_valid_o) |-> mode_valid_o && $stable(mode_o))
        else $error("mode changed after reset");
    AST_STB_ONCHIP:
    assert property (mem_stb_o |-> !(mem_region_o inside {REGION_NONE, REGION_EXTERNAL}))
        else $error("on-chip strobe to unmapped region");
    AST_BOOT_VECTOR:
    assert property (take && mode_o == MODE_BOOTSTRAP && cpu_addr_i[15:6] == 10'h3ff
        |-> ##8 mem_stb_o && mem_region_o == REGION_BOOT_ROM
        && mem_addr_o == {10'h2ff, $past(cpu_addr_i[5:0], 8)})
        else $error("boot vector not remapped");
endmodule
bind mode_select_memory_map_bus mode_map_sva chk (.sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i), .cpu_req_i(cpu_req_i), .cpu_we_i(cpu_we_i),
    .cpu_addr_i(cpu_addr_i), .cpu_wdata_i(cpu_wdata_i), .cpu_ready_o(cpu_ready_o),
    .cpu_ack_o(cpu_ack_o), .port_b_o(port_b_o), .port_c_o(port_c_o),
    .port_c_oe_o(port_c_oe_o), .handshake_line_a_o(handshake_line_a_o),
    .handshake_line_a_oe_o(handshake_line_a_oe_o), .handshake_line_b_o(handshake_line_b_o),
    .e_clock_o(e_clock_o), .mem_stb_o(mem_stb_o), .mem_region_o(mem_region_o),
    .mem_addr_o(mem_addr_o), .mode_o(mode_o), .mode_valid_o(mode_valid_o));

//--- verification/ext_bus_model.sv
`timescale 1ns/1ps
module ext_bus_model
(
    // clock
    input wire logic sys_clk_i,
    // bus pins
    input wire logic strobe_i,
    input wire logic dir_i,
    input wire logic e_clock_i,
    input wire logic [7:0] addr_hi_i,
    input wire logic [7:0] dev_c_i,
    input wire logic dev_c_oe_i,
    output logic [7:0] wire_c_o
);
    logic [7:0] mem [0:65535];
    logic [7:0] addr_lo;
    logic [7:0] last = 8'h00;
    logic drive;
    logic write_n;
    initial
    begin
        for (int i = 0; i < 65536; i++)
            mem[i] = i[7:0] ^ 8'ha5;
    end
    always_latch
        if (strobe_i)
            addr_lo <= dev_c_i;
    assign drive = dir_i && e_clock_i && !dev_c_oe_i;
    // write enable from e and direction
    assign write_n = ~(e_clock_i & ~dir_i);
    // a released line shows the inverse of its last level, never a kind value
    assign wire_c_o = dev_c_oe_i ? dev_c_i : drive ? mem[{addr_hi_i, addr_lo}] : ~last;
    always @(posedge sys_clk_i)
    begin
        last <= wire_c_o;
        if (!write_n)
            mem[{addr_hi_i, addr_lo}] <= dev_c_i;
    end
endmodule

//--- verification/mode_select_memory_map_bus_tb.sv
`timescale 1ns/1ps
module mode_select_memory_map_bus_tb
    import mode_map_pkg::*;
;
    logic sys_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic mode_hi = 1'b1;
    logic mode_lo = 1'b1;
    logic cpu_req_i = 1'b0;
    logic cpu_we_i = 1'b0;
    logic [15:0] cpu_addr_i = 16'h0000;
    logic [7:0] cpu_wdata_i = 8'h00;
    logic cpu_ready_o, cpu_ack_o, mem_stb_o, mem_we_o, gpio_hs_a_o, port_c_oe_o;
    logic [7:0] cpu_rdata_o, mem_wdata_o, gpio_c_o, port_b_o, port_c_o, port_c_i;
    logic map_wr_i = 1'b0;
    logic [3:0] ram_pg = 4'h0;
    logic [3:0] reg_pg = 4'h1;
    logic rom_dis = 1'b0;
    logic eep_dis = 1'b0;
    region_type mem_region_o, reg_q;
    logic [15:0] mem_addr_o, maddr_q;
    logic [7:0] mem_rdata_i = 8'h00;
    logic [7:0] gpio_b_i = 8'h00;
    logic [7:0] gpio_c_i = 8'h00;
    logic gpio_c_oe_i = 1'b0;
    logic gpio_hs_b_i = 1'b1;
    logic hs_a_i, hs_a_o, hs_a_oe, hs_b_o, hs_b_oe, e_clock_o, mode_valid_o, opt_we;
    mode_type mode_o;
    logic [7:0] rd_q;
    logic [8:0] we_q = 9'h000;
    int errors = 0;
    int n_compared = 0;
    int stb_n = 0;
    int stb_base = 0;
    assign hs_a_i = hs_a_oe ? hs_a_o : 1'b1;
    mode_select_memory_map_bus DUT (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
        .mode_select_high_input_i(mode_hi), .mode_select_low_input_i(mode_lo),
        .cpu_req_i(cpu_req_i), .cpu_we_i(cpu_we_i), .cpu_addr_i(cpu_addr_i),
        .cpu_wdata_i(cpu_wdata_i), .cpu_ready_o(cpu_ready_o), .cpu_ack_o(cpu_ack_o),
        .cpu_rdata_o(cpu_rdata_o), .map_wr_i(map_wr_i), .map_ram_page_i(ram_pg),
        .map_reg_page_i(reg_pg), .rom_disable_i(rom_dis), .eeprom_disable_i(eep_dis),
        .mem_region_o(mem_region_o), .mem_addr_o(mem_addr_o), .mem_stb_o(mem_stb_o),
        .mem_we_o(mem_we_o), .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i),
        .gpio_b_i(gpio_b_i), .gpio_c_i(gpio_c_i), .gpio_c_oe_i(gpio_c_oe_i),
        .gpio_hs_b_i(gpio_hs_b_i), .gpio_c_o(gpio_c_o), .gpio_hs_a_o(gpio_hs_a_o),
        .port_b_o(port_b_o), .port_c_i(port_c_i), .port_c_o(port_c_o),
        .port_c_oe_o(port_c_oe_o), .handshake_line_a_i(hs_a_i),
        .handshake_line_a_o(hs_a_o), .handshake_line_a_oe_o(hs_a_oe),
        .handshake_line_b_o(hs_b_o), .handshake_line_b_oe_o(hs_b_oe),
        .e_clock_o(e_clock_o), .mode_o(mode_o), .mode_valid_o(mode_valid_o),
        .option_write_enable_o(opt_we));
    ext_bus_model far_side (.sys_clk_i(sys_clk_i), .strobe_i(hs_a_o), .dir_i(hs_b_o),
        .e_clock_i(e_clock_o), .addr_hi_i(port_b_o), .dev_c_i(port_c_o),
        .dev_c_oe_i(port_c_oe_o), .wire_c_o(port_c_i));
    initial
    begin
        forever #2.5 sys_clk_i = ~sys_clk_i;
    end
    // on-chip memory stand-in: data is a fixed function of the address
    always @(negedge sys_clk_i)
        mem_rdata_i <= mem_addr_o[7:0] ^ 8'h3c;
    always @(posedge sys_clk_i)
        if (mem_stb_o === 1'b1)
        begin
            stb_n <= stb_n + 1;
            reg_q <= mem_region_o;
            we_q <= {mem_we_o, mem_wdata_o};
            maddr_q <= mem_addr_o;
        end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_take();
        int n;
        n = 0;
        do
            @(posedge sys_clk_i);
        while (cpu_ready_o !== 1'b1 && ++n < 40);
        chk({15'h0, cpu_ready_o}, 16'h1);
    endtask
    task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(negedge sys_clk_i);
        cpu_req_i = 1'b1;
        cpu_we_i = w;
        cpu_addr_i = a;
        cpu_wdata_i = d;
        stb_base = stb_n;
        wait_take();
        @(negedge sys_clk_i);
        cpu_req_i = 1'b0;
        repeat (8) @(posedge sys_clk_i);
        // ack stands one cycle from this edge; look once it has settled
        @(negedge sys_clk_i);
        chk({15'h0, cpu_ack_o}, 16'h1);
        rd_q = cpu_rdata_o;
    endtask
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp, input logic onchip);
        xfer(1'b0, a, 8'h00);
        chk({rd_q, 7'h0, stb_n != stb_base}, {exp, 7'h0, onchip});
    endtask
    task automatic rg(input logic [15:0] a, input region_type r);
        xfer(1'b0, a, 8'h00);
        chk({5'h0, reg_q, rd_q}, {5'h0, r, maddr_q[7:0] ^ 8'h3c});
    endtask
    task automatic do_reset(input logic hi, input logic lo, input mode_type m);
        @(negedge sys_clk_i);
        reset_n_i = 1'b0;
        mode_hi = hi;
        mode_lo = lo;
        repeat (20) @(negedge sys_clk_i);
        reset_n_i = 1'b1;
        repeat (12) @(negedge sys_clk_i);
        chk({13'h0, mode_valid_o, mode_o}, {13'h1, m});
    endtask
    task automatic t_expanded();
        do_reset(1'b1, 1'b1, MODE_EXPANDED);
        xfer(1'b1, 16'h4321, 8'h9a);
        rd_chk(16'h4321, 8'h9a, 1'b0);
        rd_chk(16'h8000, 8'ha5, 1'b0);
        @(negedge sys_clk_i);
        cpu_req_i = 1'b1;
        cpu_we_i = 1'b1;
        cpu_addr_i = 16'h5000;
        cpu_wdata_i = 8'h11;
        wait_take();
        @(negedge sys_clk_i);
        cpu_addr_i = 16'h5001;
        cpu_wdata_i = 8'h22;
        wait_take();
        @(negedge sys_clk_i);
        cpu_req_i = 1'b0;
        repeat (9) @(posedge sys_clk_i);
        rd_chk(16'h5000, 8'h11, 1'b0);
        rd_chk(16'h5001, 8'h22, 1'b0);
        rg(16'h0010, REGION_RAM);
        rg(16'h1005, REGION_REGS);
        rg(16'hd000, REGION_ROM);
        rg(16'hb600, REGION_EEPROM);
        @(negedge sys_clk_i);
        map_wr_i = 1'b1;
        ram_pg = 4'h2;
        reg_pg = 4'h2;
        rom_dis = 1'b1;
        eep_dis = 1'b1;
        @(negedge sys_clk_i);
        map_wr_i = 1'b0;
        rg(16'h2010, REGION_REGS);
        rg(16'h2050, REGION_RAM);
        rd_chk(16'h0010, 8'hb5, 1'b0);
        rd_chk(16'hd000, 8'ha5, 1'b0);
        rd_chk(16'hb600, 8'ha5, 1'b0);
        rom_dis = 1'b0;
        eep_dis = 1'b0;
    endtask
    task automatic t_single();
        gpio_b_i = 8'h3c;
        gpio_c_i = 8'h5a;
        gpio_c_oe_i = 1'b1;
        gpio_hs_b_i = 1'b0;
        rom_dis = 1'b1;
        do_reset(1'b0, 1'b1, MODE_SINGLE_CHIP);
        chk({port_b_o, port_c_o}, 16'h3c5a);
        chk({gpio_c_o, 5'h0, port_c_oe_o, hs_b_o, hs_a_oe}, 16'h5a04);
        chk({14'h0, gpio_hs_a_o, hs_b_oe}, 16'h3);
        rd_chk(16'h8000, 8'hff, 1'b0);
        rg(16'hffc0, REGION_ROM);
        @(negedge sys_clk_i);
        mode_hi = 1'b1;
        repeat (10) @(negedge sys_clk_i);
        chk({14'h0, mode_o}, {14'h0, MODE_SINGLE_CHIP});
        rom_dis = 1'b0;
        gpio_c_oe_i = 1'b0;
        gpio_hs_b_i = 1'b1;
    endtask
    task automatic t_boot();
        do_reset(1'b0, 1'b0, MODE_BOOTSTRAP);
        rg(16'hfffe, REGION_BOOT_ROM);
        chk(maddr_q, 16'hbffe);
        rg(16'hbf10, REGION_BOOT_ROM);
        xfer(1'b1, 16'h0020, 8'h66);
        chk({7'h0, we_q}, {7'h0, 1'b1, 8'h66});
    endtask
    task automatic t_test();
        do_reset(1'b1, 1'b0, MODE_TEST);
        chk({15'h0, opt_we}, 16'h1);
        xfer(1'b1, 16'h6000, 8'h77);
        rd_chk(16'h6000, 8'h77, 1'b0);
    endtask
    task automatic complete_run();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        #200000;
        errors++;
        complete_run();
    end
    initial
    begin
        t_expanded();
        t_single();
        t_boot();
        t_test();
        complete_run();
    end
endmodule
